//--- core/psr_pkg.sv
// Constants, field layout and carrier types for the processor state registers.
// Assumes a single processor clock and a synchronous, active-high module reset.
package psr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int GEN_COUNT = 16;
  localparam int GEN_IDX_W = 4;
  localparam int INT_REG_COUNT = 8;
  localparam int INT_REG_IDX_W = 3;
  localparam int INT_REG_NUM_W = 6;
  localparam int WORD_LSB = 2;

  // ****************************************
  // Register map of the plain register port
  // ****************************************
  localparam logic [ADDR_W-1:0] GEN_BASE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] GEN_SPACE_MASK = 8'hC3;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h40;

  // ****************************************
  // Status longword values and masks
  // ****************************************
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h041F_0000;
  // Implemented bits: compatibility flag and must-be-zero positions excluded.
  localparam logic [DATA_W-1:0] STATUS_IMPL_MASK = 32'h4FDF_00FF;
  localparam logic [DATA_W-1:0] STATUS_LOW_MASK = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_ONES = 32'hFFFF_FFFF;
  localparam logic [1:0] MODE_KERNEL = 2'h0;

  // ****************************************
  // Dedicated general register indices
  // ****************************************
  localparam logic [GEN_IDX_W-1:0] PROG_COUNTER_IDX = 4'hF;
  localparam logic [GEN_IDX_W-1:0] STACK_IDX = 4'hE;
  localparam logic [GEN_IDX_W-1:0] FRAME_IDX = 4'hD;
  localparam logic [GEN_IDX_W-1:0] ARG_IDX = 4'hC;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic compatibility_flag;
    logic trace_pending;
    logic [1:0] must_be_zero_hi;
    logic first_part_done;
    logic on_interrupt_stack;
    logic [1:0] present_privilege_mode;
    logic [1:0] prior_privilege_mode;
    logic must_be_zero_mid;
    logic [4:0] cpu_priority_level;
    logic [7:0] must_be_zero_lo;
    logic decimal_overflow_enable;
    logic float_underflow_enable;
    logic integer_overflow_enable;
    logic trace_enable;
    logic cond_negative;
    logic cond_zero;
    logic cond_overflow;
    logic cond_carry;
  } psr_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } psr_bus_req_t;

  typedef struct packed {
    logic push_status;
    logic ctx_save;
    logic load_status;
    logic [DATA_W-1:0] status_data;
    logic gen_wr;
    logic [GEN_IDX_W-1:0] gen_idx;
    logic [DATA_W-1:0] gen_data;
  } psr_exc_req_t;

  typedef struct packed {
    logic move_to;
    logic move_from;
    logic [INT_REG_NUM_W-1:0] number;
    logic [DATA_W-1:0] wdata;
  } psr_move_req_t;

endpackage : psr_pkg

//--- core/psr_word_cell.sv
// One storage word with a per-bit write mask and a fixed reset value.
// Assumes the parent resolves write priority before driving the enable.
`timescale 1ns/1ps
`default_nettype none

module psr_word_cell #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wr_mask_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output var logic [WIDTH-1:0] value_out
);

  // ****************************************
  // Masked merge
  // ****************************************
  logic [WIDTH-1:0] next_value;

  // Masked bits take new data; the rest keep their stored value.
  assign next_value = (value_out & ~wr_mask_in) | (wr_data_in & wr_mask_in);

  // Storage updates on each rising edge with the merged word when enabled.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      value_out <= RESET_VALUE;
    end else if (wr_en_in) begin
      value_out <= next_value;
    end
  end

endmodule : psr_word_cell

`default_nettype wire

//--- core/psr_state_regs.sv
// Processor state: general registers, status longword and internal registers.
// Assumes the execution unit drives the register port and the exception
// sequencer drives its own request group, both synchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - General registers and the low status word are open to every mode, the upper status half only to kernel mode.
// - Internal registers are reached only by the move-to and move-from instructions, and only in kernel mode.
// - There are sixteen general registers of 32 bits each, bit 0 least significant.
// - Register 15 is the program counter, 14 the stack pointer, 13 the frame pointer and 12 the argument pointer.
// - An exception or interrupt pushes the status longword, and a context switch stores it to the process control block.
// - Reset loads the status longword with 041F0000 hexadecimal.
// - Status bit 31 always reads zero and a written one there has no effect.
// - The upper status half holds trace pending, first part done, interrupt stack, both modes and the priority level.
// - Status bit 7 is plain read and write storage that steers nothing.
// - Status bits 6, 5 and 4 hold the underflow, integer overflow and trace enables.
// - Status bits 3 to 0 hold the negative, zero, overflow and carry condition codes.
module psr_state_regs (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire psr_pkg::psr_bus_req_t bus_req_in,
  output var logic [psr_pkg::DATA_W-1:0] bus_rdata_out,
  input wire psr_pkg::psr_exc_req_t exc_req_in,
  input wire psr_pkg::psr_move_req_t move_req_in,
  output var logic [psr_pkg::DATA_W-1:0] move_rdata_out,
  output var logic access_fault_out,
  output var psr_pkg::psr_status_t status_out,
  output var logic [psr_pkg::DATA_W-1:0] saved_status_out,
  output var logic push_strobe_out,
  output var logic pcb_store_out,
  output var logic [psr_pkg::DATA_W-1:0] program_counter_out,
  output var logic [psr_pkg::DATA_W-1:0] stack_pointer_out,
  output var logic [psr_pkg::DATA_W-1:0] frame_pointer_out,
  output var logic [psr_pkg::DATA_W-1:0] argument_pointer_out
);
  import psr_pkg::*;

  // ****************************************
  // Storage outputs
  // ****************************************
  logic [DATA_W-1:0] gen_q [GEN_COUNT];
  logic [DATA_W-1:0] int_reg_q [INT_REG_COUNT];
  logic [DATA_W-1:0] status_q;

  // ****************************************
  // Register port decode
  // ****************************************
  logic kernel_mode;
  logic bus_hit_gen;
  logic bus_hit_status;
  logic bus_unmapped;
  logic [GEN_IDX_W-1:0] bus_gen_idx;

  // Privilege comes from the live mode field, so a mode change is felt next cycle.
  assign kernel_mode = status_out.present_privilege_mode == MODE_KERNEL;
  assign bus_hit_gen = (bus_req_in.addr & GEN_SPACE_MASK) == GEN_BASE_ADDR;
  assign bus_hit_status = bus_req_in.addr == STATUS_ADDR;
  assign bus_unmapped = !bus_hit_gen && !bus_hit_status;
  assign bus_gen_idx = bus_req_in.addr[WORD_LSB +: GEN_IDX_W];

  // ****************************************
  // General registers
  // ****************************************
  logic [GEN_COUNT-1:0] gen_exc_hit;
  logic [GEN_COUNT-1:0] gen_bus_hit;
  logic [GEN_COUNT-1:0] gen_wr_en;
  logic [DATA_W-1:0] gen_wr_data [GEN_COUNT];

  // Each word arbitrates its own two writers; the sequencer takes precedence.
  for (genvar gi = 0; gi < GEN_COUNT; gi++) begin : g_gen
    assign gen_exc_hit[gi] = exc_req_in.gen_wr
      && exc_req_in.gen_idx == GEN_IDX_W'(gi);
    assign gen_bus_hit[gi] = bus_req_in.wr && bus_hit_gen
      && bus_gen_idx == GEN_IDX_W'(gi);
    assign gen_wr_en[gi] = gen_exc_hit[gi] || gen_bus_hit[gi];
    assign gen_wr_data[gi] = gen_exc_hit[gi] ? exc_req_in.gen_data
      : bus_req_in.wdata;

    psr_word_cell #(
      .WIDTH(DATA_W),
      .RESET_VALUE(WORD_ZERO)
    ) u_gen_cell (
      .clk_in(core_clk_in),
      .rst_in(sys_rst_in),
      .wr_en_in(gen_wr_en[gi]),
      .wr_mask_in(WORD_ONES),
      .wr_data_in(gen_wr_data[gi]),
      .value_out(gen_q[gi])
    );
  end

  // Dedicated pointer roles are plain views of the stored words.
  assign program_counter_out = gen_q[PROG_COUNTER_IDX];
  assign stack_pointer_out = gen_q[STACK_IDX];
  assign frame_pointer_out = gen_q[FRAME_IDX];
  assign argument_pointer_out = gen_q[ARG_IDX];

  // ****************************************
  // Status longword
  // ****************************************
  logic status_exc_wr;
  logic status_bus_wr;
  logic status_wr_en;
  logic [DATA_W-1:0] status_wr_data;
  logic [DATA_W-1:0] status_wr_mask;
  logic [DATA_W-1:0] status_bus_mask;
  logic [DATA_W-1:0] status_view;

  // Outside kernel mode only the low word is writable; the upper half holds.
  assign status_bus_mask = kernel_mode ? STATUS_IMPL_MASK
    : (STATUS_IMPL_MASK & STATUS_LOW_MASK);
  assign status_exc_wr = exc_req_in.load_status;
  assign status_bus_wr = bus_req_in.wr && bus_hit_status;
  assign status_wr_en = status_exc_wr || status_bus_wr;
  assign status_wr_data = status_exc_wr ? exc_req_in.status_data
    : bus_req_in.wdata;
  // The implemented mask never covers bit 31 or the must-be-zero positions,
  // so those read zero whatever a careless writer sends.
  assign status_wr_mask = status_exc_wr ? STATUS_IMPL_MASK
    : status_bus_mask;

  psr_word_cell #(
    .WIDTH(DATA_W),
    .RESET_VALUE(STATUS_RESET)
  ) u_status_cell (
    .clk_in(core_clk_in),
    .rst_in(sys_rst_in),
    .wr_en_in(status_wr_en),
    .wr_mask_in(status_wr_mask),
    .wr_data_in(status_wr_data),
    .value_out(status_q)
  );

  // The field layout lives in the struct type; bit 7 feeds nothing here.
  assign status_out = psr_status_t'(status_q);
  // Non-kernel reads of the status see only the low word.
  assign status_view = kernel_mode ? status_q
    : (status_q & STATUS_LOW_MASK);

  // ****************************************
  // Internal processor registers
  // ****************************************
  logic move_allowed;
  logic move_in_range;
  logic [INT_REG_IDX_W-1:0] move_idx;
  logic [INT_REG_COUNT-1:0] int_wr_en;

  // Only the move instructions reach this space, and only from kernel mode.
  assign move_allowed = kernel_mode;
  assign move_in_range = move_req_in.number < INT_REG_NUM_W'(INT_REG_COUNT);
  assign move_idx = move_req_in.number[INT_REG_IDX_W-1:0];

  // Unimplemented numbers read zero and ignore writes.
  for (genvar ri = 0; ri < INT_REG_COUNT; ri++) begin : g_int
    assign int_wr_en[ri] = move_req_in.move_to && move_allowed && move_in_range
      && move_idx == INT_REG_IDX_W'(ri);

    psr_word_cell #(
      .WIDTH(DATA_W),
      .RESET_VALUE(WORD_ZERO)
    ) u_int_cell (
      .clk_in(core_clk_in),
      .rst_in(sys_rst_in),
      .wr_en_in(int_wr_en[ri]),
      .wr_mask_in(WORD_ONES),
      .wr_data_in(move_req_in.wdata),
      .value_out(int_reg_q[ri])
    );
  end

  // ****************************************
  // Read data and fault reporting
  // ****************************************
  logic [DATA_W-1:0] next_bus_rdata;
  logic [DATA_W-1:0] next_move_rdata;
  logic next_fault;
  logic move_refused;

  assign next_bus_rdata = bus_hit_gen ? gen_q[bus_gen_idx]
    : (bus_hit_status ? status_view : WORD_ZERO);
  assign next_move_rdata = (move_allowed && move_in_range) ? int_reg_q[move_idx]
    : WORD_ZERO;
  assign move_refused = (move_req_in.move_to || move_req_in.move_from)
    && !move_allowed;
  assign next_fault = ((bus_req_in.wr || bus_req_in.rd) && bus_unmapped)
    || move_refused;

  // Read data appear in the cycle after the strobe and hold until the next read.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      bus_rdata_out <= WORD_ZERO;
      move_rdata_out <= WORD_ZERO;
      access_fault_out <= 1'b0;
    end else begin
      if (bus_req_in.rd) begin
        bus_rdata_out <= next_bus_rdata;
      end
      if (move_req_in.move_from) begin
        move_rdata_out <= next_move_rdata;
      end
      access_fault_out <= next_fault;
    end
  end

  // ****************************************
  // Exception and context save
  // ****************************************
  // The value captured is the one before any load in the same cycle,
  // which is what the stack frame must hold.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      push_strobe_out <= 1'b0;
      pcb_store_out <= 1'b0;
      saved_status_out <= WORD_ZERO;
    end else begin
      push_strobe_out <= exc_req_in.push_status;
      pcb_store_out <= exc_req_in.ctx_save;
      if (exc_req_in.push_status || exc_req_in.ctx_save) begin
        saved_status_out <= status_q;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence push_req_s;
    exc_req_in.push_status || exc_req_in.ctx_save;
  endsequence

  sequence push_done_s;
    (push_strobe_out || pcb_store_out) && saved_status_out == $past(status_q);
  endsequence

  compat_zero_a: assert property (status_q[DATA_W-1] == 1'b0)
    else $error("status bit 31 is set");

  init_value_a: assert property ($past(sys_rst_in) |-> status_q == STATUS_RESET)
    else $error("status not at init value after reset");

  user_upper_hold_a: assert property (
    status_bus_wr && !status_exc_wr && !kernel_mode
    |=> (status_q & ~STATUS_LOW_MASK) == ($past(status_q) & ~STATUS_LOW_MASK))
    else $error("user write changed upper status half");

  user_lower_write_a: assert property (
    status_bus_wr && !status_exc_wr && !kernel_mode
    |=> (status_q & STATUS_LOW_MASK)
      == ($past(bus_req_in.wdata) & STATUS_IMPL_MASK & STATUS_LOW_MASK))
    else $error("user write to low status word lost");

  move_refuse_a: assert property (
    move_req_in.move_to && !kernel_mode
    |=> access_fault_out && int_reg_q[$past(move_idx)] == $past(int_reg_q[move_idx]))
    else $error("non-kernel move reached internal register");

  gen_write_a: assert property (
    gen_bus_hit[bus_gen_idx] && !gen_exc_hit[bus_gen_idx]
    |=> gen_q[$past(bus_gen_idx)] == $past(bus_req_in.wdata))
    else $error("general register write lost");

  exc_priority_a: assert property (
    gen_bus_hit[exc_req_in.gen_idx] && exc_req_in.gen_wr
    |=> gen_q[$past(exc_req_in.gen_idx)] == $past(exc_req_in.gen_data))
    else $error("ordinary write beat exception write");

  pc_view_a: assert property (
    gen_exc_hit[PROG_COUNTER_IDX]
    |=> program_counter_out == $past(exc_req_in.gen_data))
    else $error("program counter view wrong");

  status_load_a: assert property (
    status_exc_wr
    |=> status_q == ($past(exc_req_in.status_data) & STATUS_IMPL_MASK))
    else $error("status load wrong");

  push_save_a: assert property (push_req_s |=> push_done_s)
    else $error("status not saved on push");

  // Reserved positions must stay clear whichever writer touched the word.
  reserved_zero_a: assert property ((status_q & ~STATUS_IMPL_MASK) == WORD_ZERO)
    else $error("status reserved bit set");

  user_status_read_a: assert property (
    bus_req_in.rd && bus_hit_status && !kernel_mode
    |=> bus_rdata_out == ($past(status_q) & STATUS_LOW_MASK))
    else $error("user read saw upper status half");

  move_read_refuse_a: assert property (
    move_req_in.move_from && !kernel_mode
    |=> move_rdata_out == WORD_ZERO && access_fault_out)
    else $error("non-kernel move read returned data");

  move_write_a: assert property (
    move_req_in.move_to && kernel_mode && move_in_range
    |=> int_reg_q[$past(move_idx)] == $past(move_req_in.wdata))
    else $error("kernel move write lost");

  unmapped_fault_a: assert property (
    (bus_req_in.wr || bus_req_in.rd) && bus_unmapped |=> access_fault_out)
    else $error("unmapped access not reported");

  // A load from the sequencer must win over a port write in the same cycle.
  status_prio_a: assert property (
    status_exc_wr && status_bus_wr
    |=> status_q == ($past(exc_req_in.status_data) & STATUS_IMPL_MASK))
    else $error("ordinary write beat status load");

endmodule : psr_state_regs

`default_nettype wire

//--- sim/psr_seq_model.sv
// Model of the exception sequencer that drives the exception group.
// Assumes the bench calls its task and that it shares core_clk_in with the block.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Exception sequencer model
// ****************************************
module psr_seq_model (
  input wire logic clk_in,
  output var psr_pkg::psr_exc_req_t exc_out
);
  import psr_pkg::*;
  // Positions this writer keeps; it clears the must-be-zero fields but lets bit 31 through to the block.
  localparam logic [DATA_W-1:0] MBZ_CLEAR = 32'hCFDF_00FF;

  initial exc_out = '0;

  // One request cycle: raised after an edge, dropped after the next one.
  task automatic exc(input logic [3:0] kind, input logic [DATA_W-1:0] sdata,
      input logic [GEN_IDX_W-1:0] idx, input logic [DATA_W-1:0] gdata);
    @(posedge clk_in);
    exc_out <= '{push_status: kind[0], ctx_save: kind[1], load_status: kind[2],
      status_data: sdata & MBZ_CLEAR, gen_wr: kind[3], gen_idx: idx, gen_data: gdata};
    @(posedge clk_in);
    exc_out <= '0;
  endtask : exc
endmodule : psr_seq_model
`default_nettype wire

//--- sim/processor_state_registers_tb_top.sv
// Self-checking bench for the processor state registers.
// Assumes the block's package and the sequencer model are compiled first.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench top
// ****************************************
module processor_state_registers_tb_top;
  import psr_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  psr_bus_req_t bus_req = '0;
  psr_move_req_t move_req = '0;
  psr_exc_req_t exc_req;
  psr_status_t status;
  logic [DATA_W-1:0] bus_rdata, move_rdata, saved, pc, sp, fp, ap, d;
  logic fault, push_stb, pcb_stb, f;
  int n_fail = 0;
  int n_tests = 0;

  psr_state_regs dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .bus_req_in(bus_req), .bus_rdata_out(bus_rdata), .exc_req_in(exc_req),
    .move_req_in(move_req), .move_rdata_out(move_rdata), .access_fault_out(fault),
    .status_out(status), .saved_status_out(saved), .push_strobe_out(push_stb),
    .pcb_store_out(pcb_stb), .program_counter_out(pc), .stack_pointer_out(sp),
    .frame_pointer_out(fp), .argument_pointer_out(ap));
  psr_seq_model seq (.clk_in(core_clk_in), .exc_out(exc_req));

  // A 100 ns clock.
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One register port cycle; read data and fault are taken in the answer cycle.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    @(posedge core_clk_in);
    bus_req <= '{wr: wr, rd: !wr, addr: a, wdata: wd};
    @(posedge core_clk_in);
    bus_req <= '0;
    #1 d = bus_rdata;
    f = fault;
  endtask : bus

  // One move-to or move-from cycle.
  task automatic mv(input logic to, input logic [5:0] num, input logic [DATA_W-1:0] wd);
    @(posedge core_clk_in);
    move_req <= '{move_to: to, move_from: !to, number: num, wdata: wd};
    @(posedge core_clk_in);
    move_req <= '0;
    #1 d = move_rdata;
    f = fault;
  endtask : mv

  task automatic t_reset;
    chk("status", status, 32'h041F_0000);
    chk("pc", pc, WORD_ZERO);
    bus(1'b0, STATUS_ADDR, WORD_ZERO);
    chk("status read", d, 32'h041F_0000);
    $display("t_reset done");
  endtask : t_reset

  // Every general register, the named pointers, and two refused addresses.
  task automatic t_gen;
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 8'(4 * i), 32'h0101_0101 * 32'(i));
    end
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 8'(4 * i), WORD_ZERO);
      chk("gen read", d, 32'h0101_0101 * 32'(i));
    end
    chk("pc", pc, 32'h0F0F_0F0F);
    chk("sp", sp, 32'h0E0E_0E0E);
    chk("fp", fp, 32'h0D0D_0D0D);
    chk("ap", ap, 32'h0C0C_0C0C);
    bus(1'b0, 8'h44, WORD_ZERO);
    chk("unmapped read", d, WORD_ZERO);
    chk("unmapped fault", 32'(f), 32'h1);
    bus(1'b1, 8'h02, WORD_ONES);
    chk("misaligned fault", 32'(f), 32'h1);
    bus(1'b0, 8'h00, WORD_ZERO);
    chk("reg0 kept", d, WORD_ZERO);
    $display("t_gen done");
  endtask : t_gen

  // Field masking, a drop to user mode, then an exception back to kernel.
  task automatic t_status;
    bus(1'b1, STATUS_ADDR, WORD_ONES);
    chk("status all ones", status, 32'h4FDF_00FF);
    bus(1'b0, STATUS_ADDR, WORD_ZERO);
    chk("user status read", d, 32'h0000_00FF);
    bus(1'b1, STATUS_ADDR, 32'h0000_FF5A);
    chk("user status write", status, 32'h4FDF_005A);
    bus(1'b1, 8'h04, 32'h5555_0001);
    bus(1'b0, 8'h04, WORD_ZERO);
    chk("user gen read", d, 32'h5555_0001);
    mv(1'b1, 6'h03, 32'hDEAD_0001);
    chk("user move_to fault", 32'(f), 32'h1);
    mv(1'b0, 6'h03, WORD_ZERO);
    chk("user move_from", d, WORD_ZERO);
    chk("user move fault", 32'(f), 32'h1);
    seq.exc(4'b0101, 32'h841F_0013, 4'h0, WORD_ZERO);
    #1 chk("push strobe", 32'(push_stb), 32'h1);
    chk("pushed status", saved, 32'h4FDF_005A);
    chk("loaded status", status, 32'h041F_0013);
    seq.exc(4'b0010, WORD_ZERO, 4'h0, WORD_ZERO);
    #1 chk("pcb strobe", 32'(pcb_stb), 32'h1);
    chk("push strobe low", 32'(push_stb), 32'h0);
    chk("pcb status", saved, 32'h041F_0013);
    $display("t_status done");
  endtask : t_status

  // Internal registers in kernel mode, after the refused user write.
  task automatic t_move;
    mv(1'b0, 6'h03, WORD_ZERO);
    chk("refused write kept out", d, WORD_ZERO);
    mv(1'b1, 6'h03, 32'hA5A5_0003);
    mv(1'b0, 6'h03, WORD_ZERO);
    chk("kernel move", d, 32'hA5A5_0003);
    chk("kernel fault", 32'(f), 32'h0);
    mv(1'b1, 6'h08, WORD_ONES);
    mv(1'b0, 6'h08, WORD_ZERO);
    chk("number 8", d, WORD_ZERO);
    $display("t_move done");
  endtask : t_move

  // A port write and a sequencer write in one cycle, first to the program counter, then to the status longword.
  task automatic t_prio;
    fork
      bus(1'b1, 8'h3C, 32'h1111_0000);
      seq.exc(4'b1000, WORD_ZERO, PROG_COUNTER_IDX, 32'h2222_0000);
    join
    #1 chk("pc priority", pc, 32'h2222_0000);
    fork
      bus(1'b1, STATUS_ADDR, 32'h0000_0011);
      seq.exc(4'b0100, 32'h041F_0022, 4'h0, WORD_ZERO);
    join
    #1 chk("status priority", status, 32'h041F_0022);
    $display("t_prio done");
  endtask : t_prio

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // The tests need about 110 cycles; this cuts a hang short.
  initial begin
    repeat (3000) @(posedge core_clk_in);
    n_fail++;
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    #1 t_reset();
    t_gen();
    t_status();
    t_move();
    t_prio();
    end_sim();
  end
endmodule : processor_state_registers_tb_top
`default_nettype wire
